// *** verilog/etcs_pkg.sv ***
/*
 * Constants and types for the 8-bit timer control and status block.
 * Assumes a byte-wide register port with 16-bit addresses.
 */
package etcs_pkg;

	// ------------------------------------------------------------
	// Register addresses and reset values
	// ------------------------------------------------------------
	localparam logic [15:0] ADDR_CTRL = 16'hFED0;
	localparam logic [15:0] ADDR_STAT = 16'hFED1;
	localparam logic [15:0] ADDR_CONST_A = 16'hFED2;
	localparam logic [15:0] ADDR_CONST_B = 16'hFED3;
	localparam logic [15:0] ADDR_COUNT = 16'hFED4;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] STAT_RST = 8'h10;
	localparam logic [7:0] CONST_RST = 8'hFF;
	localparam logic [7:0] COUNT_RST = 8'h00;
	localparam logic [7:0] COUNT_MAX = 8'hFF;
	localparam logic [7:0] READ_IDLE = 8'h00;

	// ------------------------------------------------------------
	// Status field layout
	// ------------------------------------------------------------
	localparam int FLAG_LSB = 5;
	localparam int FLAG_B = 2;
	localparam int FLAG_A = 1;
	localparam int FLAG_WRAP = 0;
	localparam int RSV_BIT = 4;
	localparam logic RSV_VAL = 1'b1;

	// ------------------------------------------------------------
	// Clock, clear and output select codes
	// ------------------------------------------------------------
	localparam logic [2:0] CKS_OFF = 3'h0;
	localparam logic [2:0] CKS_DIV8 = 3'h1;
	localparam logic [2:0] CKS_DIV64 = 3'h2;
	localparam logic [2:0] CKS_DIV1024 = 3'h3;
	localparam logic [2:0] CKS_OFF_EXT = 3'h4;
	localparam logic [2:0] CKS_RISE = 3'h5;
	localparam logic [2:0] CKS_FALL = 3'h6;
	localparam logic [2:0] CKS_BOTH = 3'h7;
	localparam logic [1:0] CCLR_NONE = 2'h0;
	localparam logic [1:0] CCLR_A = 2'h1;
	localparam logic [1:0] CCLR_B = 2'h2;
	localparam logic [1:0] CCLR_EXT = 2'h3;
	localparam logic [1:0] OS_NONE = 2'h0;
	localparam logic [1:0] OS_ZERO = 2'h1;
	localparam logic [1:0] OS_ONE = 2'h2;
	localparam logic [1:0] OS_TOGGLE = 2'h3;

	// ------------------------------------------------------------
	// Prescaler taps, as powers of two
	// ------------------------------------------------------------
	localparam int PRE_W = 10;
	localparam int TAP_DIV8 = 3;
	localparam int TAP_DIV64 = 6;
	localparam int TAP_DIV1024 = 10;

	// ------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} etcs_req_t;

	typedef struct packed {
		logic match_b_irq_en;
		logic match_a_irq_en;
		logic wrap_irq_en;
		logic [1:0] clear_sel;
		logic [2:0] clk_sel;
	} etcs_ctrl_t;

	typedef struct packed {
		logic match_b_irq;
		logic match_a_irq;
		logic wrap_irq;
	} etcs_irq_t;

endpackage

// *** verilog/etcs_prescale.sv ***
/*
 * Prescaler, held clear in standby, giving one-cycle enable pulses at clk/8,
 * clk/64 and clk/1024. Assumes one system clock.
 */
`timescale 1ns/1ps
module etcs_prescale import etcs_pkg::*; #(
	parameter int WIDTH = PRE_W,
	parameter int TAP0 = TAP_DIV8,
	parameter int TAP1 = TAP_DIV64,
	parameter int TAP2 = TAP_DIV1024
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic standby,
	output logic [2:0] tick
);
	localparam int TAPS [3] = '{TAP0, TAP1, TAP2};
	logic [WIDTH-1:0] div;

	// ------------------------------------------------------------
	// Divider
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			div <= '0;
		end else if (standby) begin
			div <= '0;
		end else begin
			div <= div + 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Pulse on falling edge of each divided clock
	// ------------------------------------------------------------
	for (genvar i = 0; i < 3; i++) begin : g_tap
		assign tick[i] = &div[TAPS[i]-1:0];
	end
endmodule

// *** verilog/etcs_edge.sv ***
/*
 * Samples a pin on the system clock and reports its edges as
 * one-cycle pulses. Assumes the pin is slow against the clock.
 */
`timescale 1ns/1ps
module etcs_edge (
	input wire logic clk,
	input wire logic rst,
	input wire logic pin,
	output logic rise,
	output logic fall
);
	logic meta;
	logic sync;
	logic last;

	// ------------------------------------------------------------
	// Sampling and edge detect
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta <= 1'b0;
			sync <= 1'b0;
			last <= 1'b0;
		end else begin
			meta <= pin;
			sync <= meta;
			last <= sync;
		end
	end

	assign rise = sync && !last;
	assign fall = !sync && last;
endmodule

// *** verilog/etcs_top.sv ***
/*
 * Control and status logic of an 8-bit timer: clock select, counter
 * clear select, compare and wrap flags, interrupt requests and the
 * timer output pin. Assumes a CPU register port with read data one
 * cycle after the read strobe, a transfer controller that pulses a
 * clear for each compare interrupt it serves, and a standby level.
 */
// Our own choice: strobed register access.
`timescale 1ns/1ps
module etcs_top import etcs_pkg::*; (
	input wire logic clk,
	input wire logic rst,
	input wire etcs_req_t req,
	output logic [7:0] rdata,
	input wire logic standby,
	input wire logic xfer_clr_a,
	input wire logic xfer_clr_b,
	input wire logic ext_count_pin,
	input wire logic ext_clear_pin,
	output etcs_irq_t irq,
	output logic timer_out_pin,
	output logic timer_out_en
);
	etcs_ctrl_t ctrl;
	logic [2:0] flag;
	logic [2:0] armed;
	logic [3:0] out_sel;
	logic [7:0] const_a;
	logic [7:0] const_b;
	logic [7:0] count;
	logic [2:0] pre_tick;
	logic cnt_rise;
	logic cnt_fall;
	logic clr_rise;
	logic tick;
	logic match_a;
	logic match_b;
	logic cnt_clear;
	logic wrap_ev;
	logic [2:0] set_ev;
	logic [2:0] xfer_clr;
	logic [2:0] sw_clr;
	logic [1:0] next_act;
	logic [7:0] stat_val;
	logic wr_ctrl;
	logic wr_stat;
	logic wr_ca;
	logic wr_cb;
	logic wr_cnt;
	logic rd_stat;

	// ------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------
	function automatic logic hit(input etcs_req_t r,
		input logic [15:0] a);
		return r.addr == a;
	endfunction

	assign wr_ctrl = req.wr && hit(req, ADDR_CTRL);
	assign wr_stat = req.wr && hit(req, ADDR_STAT);
	assign wr_ca = req.wr && hit(req, ADDR_CONST_A);
	assign wr_cb = req.wr && hit(req, ADDR_CONST_B);
	assign wr_cnt = req.wr && hit(req, ADDR_COUNT);
	assign rd_stat = req.rd && hit(req, ADDR_STAT);

	// ------------------------------------------------------------
	// Clock sources
	// ------------------------------------------------------------
	etcs_prescale u_pre (
		.clk(clk),
		.rst(rst),
		.standby(standby),
		.tick(pre_tick)
	);

	etcs_edge u_cnt_pin (
		.clk(clk),
		.rst(rst),
		.pin(ext_count_pin),
		.rise(cnt_rise),
		.fall(cnt_fall)
	);

	etcs_edge u_clr_pin (
		.clk(clk),
		.rst(rst),
		.pin(ext_clear_pin),
		.rise(clr_rise),
		.fall()
	);

	always_comb begin
		case (ctrl.clk_sel)
			CKS_DIV8: tick = pre_tick[0];
			CKS_DIV64: tick = pre_tick[1];
			CKS_DIV1024: tick = pre_tick[2];
			CKS_RISE: tick = cnt_rise;
			CKS_FALL: tick = cnt_fall;
			CKS_BOTH: tick = cnt_rise || cnt_fall;
			default: tick = 1'b0;
		endcase
	end

	// ------------------------------------------------------------
	// Compare, clear and wrap events
	// ------------------------------------------------------------
	assign match_a = tick && count == const_a && !wr_ca;
	assign match_b = tick && count == const_b && !wr_cb;

	always_comb begin
		case (ctrl.clear_sel)
			CCLR_A: cnt_clear = match_a;
			CCLR_B: cnt_clear = match_b;
			CCLR_EXT: cnt_clear = clr_rise;
			default: cnt_clear = 1'b0;
		endcase
	end

	assign wrap_ev = tick && count == COUNT_MAX && !cnt_clear &&
		!wr_cnt;

	// ------------------------------------------------------------
	// Counter
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			count <= COUNT_RST;
		end else if (standby) begin
			count <= COUNT_RST;
		end else if (cnt_clear) begin
			count <= COUNT_RST;
		end else if (wr_cnt) begin
			count <= req.wdata;
		end else if (tick) begin
			count <= count + 8'h01;
		end
	end

	// ------------------------------------------------------------
	// Constant registers
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			const_a <= CONST_RST;
			const_b <= CONST_RST;
		end else if (standby) begin
			const_a <= CONST_RST;
			const_b <= CONST_RST;
		end else begin
			if (wr_ca) begin
				const_a <= req.wdata;
			end
			if (wr_cb) begin
				const_b <= req.wdata;
			end
		end
	end

	// ------------------------------------------------------------
	// Control register
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl <= CTRL_RST;
		end else if (standby) begin
			ctrl <= CTRL_RST;
		end else if (wr_ctrl) begin
			ctrl <= req.wdata;
		end
	end

	// ------------------------------------------------------------
	// Flags with read-then-write-zero clearing
	// ------------------------------------------------------------
	assign set_ev[FLAG_B] = match_b;
	assign set_ev[FLAG_A] = match_a;
	assign set_ev[FLAG_WRAP] = wrap_ev;
	assign xfer_clr[FLAG_B] = xfer_clr_b;
	assign xfer_clr[FLAG_A] = xfer_clr_a;
	assign xfer_clr[FLAG_WRAP] = 1'b0;

	for (genvar i = 0; i < 3; i++) begin : g_flag
		assign sw_clr[i] = wr_stat && !req.wdata[FLAG_LSB+i] &&
			armed[i];

		always_ff @(posedge clk or posedge rst) begin
			if (rst) begin
				flag[i] <= 1'b0;
			end else if (standby) begin
				flag[i] <= 1'b0;
			end else if (set_ev[i]) begin
				flag[i] <= 1'b1;
			end else if (sw_clr[i] || xfer_clr[i]) begin
				flag[i] <= 1'b0;
			end
		end

		always_ff @(posedge clk or posedge rst) begin
			if (rst) begin
				armed[i] <= 1'b0;
			end else if (standby) begin
				armed[i] <= 1'b0;
			end else if (rd_stat) begin
				armed[i] <= flag[i];
			end else if (wr_stat) begin
				armed[i] <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Output selects
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			out_sel <= STAT_RST[3:0];
		end else if (standby) begin
			out_sel <= STAT_RST[3:0];
		end else if (wr_stat) begin
			out_sel <= req.wdata[3:0];
		end
	end

	// ------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------
	always_comb begin
		stat_val = {flag, RSV_VAL, out_sel};
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdata <= READ_IDLE;
		end else if (!req.rd) begin
			rdata <= READ_IDLE;
		end else begin
			case (req.addr)
				ADDR_CTRL: rdata <= ctrl;
				ADDR_STAT: rdata <= stat_val;
				ADDR_CONST_A: rdata <= const_a;
				ADDR_CONST_B: rdata <= const_b;
				ADDR_COUNT: rdata <= count;
				default: rdata <= READ_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Interrupt requests
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irq <= '0;
		end else begin
			irq.match_b_irq <= flag[FLAG_B] &&
				ctrl.match_b_irq_en;
			irq.match_a_irq <= flag[FLAG_A] &&
				ctrl.match_a_irq_en;
			irq.wrap_irq <= flag[FLAG_WRAP] &&
				ctrl.wrap_irq_en;
		end
	end

	// ------------------------------------------------------------
	// Timer output
	// ------------------------------------------------------------
	function automatic logic [1:0] act(input logic [1:0] os,
		input logic m);
		return m ? os : OS_NONE;
	endfunction

	always_comb begin
		// Codes rank as toggle > one > zero > keep
		next_act = act(out_sel[3:2], match_b);
		if (act(out_sel[1:0], match_a) > next_act) begin
			next_act = act(out_sel[1:0], match_a);
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			timer_out_pin <= 1'b0;
		end else if (standby) begin
			timer_out_pin <= 1'b0;
		end else begin
			case (next_act)
				OS_ZERO: timer_out_pin <= 1'b0;
				OS_ONE: timer_out_pin <= 1'b1;
				OS_TOGGLE: timer_out_pin <= !timer_out_pin;
				default: timer_out_pin <= timer_out_pin;
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			timer_out_en <= 1'b0;
		end else begin
			timer_out_en <= |out_sel;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_read_stat;
		req.rd && req.addr == ADDR_STAT;
	endsequence

	sequence s_read_back;
		##1 rdata[RSV_BIT];
	endsequence

	chk_ctrl_standby: assert property (
		standby |=> ctrl == CTRL_RST)
		else $error("control not cleared by standby");
	chk_stat_standby: assert property (
		standby |=> stat_val == STAT_RST)
		else $error("status not reset by standby");
	chk_irq_b_req: assert property (
		flag[FLAG_B] && ctrl.match_b_irq_en |=> irq.match_b_irq)
		else $error("compare B request missing");
	chk_irq_a_mask: assert property (
		!ctrl.match_a_irq_en |=> !irq.match_a_irq)
		else $error("compare A request not masked");
	chk_irq_wrap_req: assert property (
		flag[FLAG_WRAP] && ctrl.wrap_irq_en |=> irq.wrap_irq)
		else $error("wrap request missing");
	chk_match_a_flag: assert property (
		tick && count == const_a && !wr_ca && !standby |=> flag[FLAG_A])
		else $error("compare A flag not set");
	chk_wrap_flag: assert property (
		wrap_ev && !standby |=> flag[FLAG_WRAP] && count == COUNT_RST)
		else $error("wrap flag or roll over wrong");
	chk_no_sw_set: assert property (
		$rose(flag[FLAG_B]) |-> $past(match_b))
		else $error("compare B flag set without match");
	chk_clear_armed: assert property (
		$fell(flag[FLAG_A]) && !$past(xfer_clr_a) && !$past(standby)
		|-> $past(armed[FLAG_A]))
		else $error("flag cleared without prior read");
	chk_xfer_clear: assert property (
		xfer_clr_b && !match_b && !standby |=> !flag[FLAG_B])
		else $error("transfer clear ignored");
	chk_rsv_read: assert property (
		s_read_stat |-> s_read_back)
		else $error("reserved bit not read as one");
	chk_stop_hold: assert property (
		ctrl.clk_sel == CKS_OFF_EXT && !wr_cnt && !cnt_clear &&
		!standby |=> $stable(count))
		else $error("stopped counter moved");
	chk_clear_sel_a: assert property (
		ctrl.clear_sel == CCLR_A && match_a && !standby
		|=> count == COUNT_RST)
		else $error("compare A clear failed");
	chk_out_disable: assert property (
		out_sel == 4'h0 |=> !timer_out_en)
		else $error("output enabled with no select");
	chk_toggle_prio: assert property (
		match_a && match_b && out_sel[1:0] == OS_TOGGLE && !standby
		|=> timer_out_pin != $past(timer_out_pin))
		else $error("toggle lost priority");
endmodule

// *** sim/etcs_xfer_model.sv ***
/*
 * Transfer controller model: serves compare interrupts by pulsing
 * the matching clear once per request.
 * Assumes level interrupt requests and one system clock.
 */
`timescale 1ns/1ps
module etcs_xfer_model import etcs_pkg::*; (
	input wire logic clk,
	input wire logic rst,
	input wire logic serve,
	input wire etcs_irq_t irq,
	output logic xfer_clr_a,
	output logic xfer_clr_b
);
	// ------------------------------------------------------------
	// One service pulse per request, re-armed when it drops
	// ------------------------------------------------------------
	logic busy_a;
	logic busy_b;
	logic fire_a;
	logic fire_b;
	assign fire_a = serve & irq.match_a_irq & ~busy_a;
	assign fire_b = serve & irq.match_b_irq & ~busy_b;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			xfer_clr_a <= 1'b0;
			xfer_clr_b <= 1'b0;
			busy_a <= 1'b0;
			busy_b <= 1'b0;
		end else begin
			xfer_clr_a <= fire_a;
			xfer_clr_b <= fire_b;
			busy_a <= fire_a | (busy_a & irq.match_a_irq);
			busy_b <= fire_b | (busy_b & irq.match_b_irq);
		end
	end
endmodule

// *** sim/tb_etcs_top.sv ***
/*
 * Self-checking bench for the timer control and status block.
 * Assumes a 100 MHz clock and the register port of the package.
 */
`timescale 1ns/1ps
module tb_etcs_top import etcs_pkg::*;;
	logic clk, rst, standby, ext_count_pin, ext_clear_pin, serve;
	logic timer_out_pin, timer_out_en, xfer_clr_a, xfer_clr_b, pin_prev;
	logic [7:0] rdata, d;
	etcs_req_t req;
	etcs_irq_t irq;
	int n_errors, cmp_count, k;
	time t_prev, t_rise;
	int div_tab[3] = '{8, 64, 1024};
	int code_tab[4] = '{4, 5, 6, 7};
	int exp_tab[4] = '{0, 3, 3, 6};

	etcs_top uut (.clk(clk), .rst(rst), .req(req), .rdata(rdata),
		.standby(standby), .xfer_clr_a(xfer_clr_a),
		.xfer_clr_b(xfer_clr_b), .ext_count_pin(ext_count_pin),
		.ext_clear_pin(ext_clear_pin), .irq(irq),
		.timer_out_pin(timer_out_pin), .timer_out_en(timer_out_en));
	etcs_xfer_model partner (.clk(clk), .rst(rst), .serve(serve),
		.irq(irq), .xfer_clr_a(xfer_clr_a), .xfer_clr_b(xfer_clr_b));

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] v);
		@(posedge clk);
		req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		req.wr <= 1'b0;
	endtask
	task automatic rd(input logic [15:0] a);
		@(posedge clk);
		req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		req.rd <= 1'b0;
		#1;
		d = rdata;
	endtask
	task automatic rchk(input logic [15:0] a, input logic [7:0] exp);
		rd(a);
		chk(d, exp);
	endtask
	task automatic cycles(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic pulse(input int which, input int n);
		repeat (n) begin
			@(posedge clk);
			if (which == 0) ext_count_pin <= 1'b1;
			else ext_clear_pin <= 1'b1;
			repeat (4) @(posedge clk);
			if (which == 0) ext_count_pin <= 1'b0;
			else ext_clear_pin <= 1'b0;
			repeat (4) @(posedge clk);
		end
	endtask
	task automatic rise(input int idx);
		int i;
		int j;
		for (i = 0; i < 5000 && irq[idx] === 1'b1; i++) cycles(1);
		for (j = 0; j < 5000 && irq[idx] !== 1'b1; j++) cycles(1);
		if (i == 5000 || irq[idx] !== 1'b1) begin
			n_errors++;
			$display("CHECK FAILED t=%0t request never rose", $time);
			end_of_test();
		end
		t_prev = t_rise;
		t_rise = $time;
	endtask
	task automatic test_done(input string s);
		$display("test %s finished", s);
	endtask

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		rst = 1'b1;
		standby = 1'b0;
		ext_count_pin = 1'b0;
		ext_clear_pin = 1'b0;
		serve = 1'b1;
		req = '0;
		n_errors = 0;
		cmp_count = 0;
		t_rise = 0;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		rchk(ADDR_CTRL, 8'h00);
		rchk(ADDR_STAT, 8'h10);
		rchk(ADDR_CONST_A, 8'hFF);
		rchk(ADDR_COUNT, 8'h00);
		rchk(16'hFED5, 8'h00);
		chk(timer_out_pin, 1'b0);
		chk(timer_out_en, 1'b0);
		wr(ADDR_STAT, 8'hFF);
		rchk(ADDR_STAT, 8'h1F);
		wr(ADDR_COUNT, 8'h5A);
		rchk(ADDR_COUNT, 8'h5A);
		test_done("reset");
		wr(ADDR_STAT, 8'h03);
		wr(ADDR_CONST_A, 8'h02);
		cycles(1);
		chk(timer_out_en, 1'b1);
		for (k = 0; k < 3; k++) begin
			wr(ADDR_CTRL, 8'h48 | 8'(k + 1));
			rise(1);
			pin_prev = timer_out_pin;
			rise(1);
			chk(32'((t_rise - t_prev) / 10), 3 * div_tab[k]);
			chk(timer_out_pin, !pin_prev);
		end
		test_done("prescale");
		wr(ADDR_CTRL, 8'h49);
		wr(ADDR_CONST_B, 8'h02);
		wr(ADDR_STAT, 8'h09);
		rise(1);
		chk(timer_out_pin, 1'b1);
		wr(ADDR_STAT, 8'h04);
		rise(1);
		chk(timer_out_pin, 1'b0);
		wr(ADDR_STAT, 8'h07);
		rise(1);
		chk(timer_out_pin, 1'b1);
		rise(1);
		chk(timer_out_pin, 1'b0);
		rd(ADDR_STAT);
		chk(d & 8'h80, 8'h80);
		test_done("output");
		wr(ADDR_CTRL, 8'h55);
		standby <= 1'b1;
		repeat (2) @(posedge clk);
		standby <= 1'b0;
		rchk(ADDR_CTRL, 8'h00);
		rchk(ADDR_STAT, 8'h10);
		rchk(ADDR_CONST_A, 8'hFF);
		chk(timer_out_en, 1'b0);
		test_done("standby");
		serve <= 1'b0;
		wr(ADDR_CONST_A, 8'h02);
		wr(ADDR_CTRL, 8'h09);
		cycles(40);
		wr(ADDR_CTRL, 8'h00);
		wr(ADDR_STAT, 8'h00);
		rchk(ADDR_STAT, 8'h50);
		chk(irq.match_a_irq, 1'b0);
		wr(ADDR_CTRL, 8'h40);
		cycles(2);
		chk(irq.match_a_irq, 1'b1);
		wr(ADDR_STAT, 8'h00);
		cycles(2);
		chk(irq.match_a_irq, 1'b0);
		rchk(ADDR_STAT, 8'h10);
		test_done("flag clear");
		wr(ADDR_CTRL, 8'h20);
		wr(ADDR_COUNT, 8'hFE);
		wr(ADDR_CTRL, 8'h21);
		rise(0);
		rd(ADDR_STAT);
		chk(d & 8'hA0, 8'hA0);
		chk(irq.match_b_irq, 1'b0);
		wr(ADDR_CTRL, 8'hA0);
		cycles(2);
		chk(irq.match_b_irq, 1'b1);
		test_done("wrap");
		for (k = 0; k < 4; k++) begin
			wr(ADDR_CTRL, 8'(code_tab[k]));
			wr(ADDR_COUNT, 8'h00);
			pulse(0, 3);
			cycles(6);
			rchk(ADDR_COUNT, 8'(exp_tab[k]));
		end
		test_done("external clock");
		wr(ADDR_CTRL, 8'h04);
		wr(ADDR_COUNT, 8'h40);
		pulse(1, 1);
		rchk(ADDR_COUNT, 8'h40);
		wr(ADDR_CTRL, 8'h1C);
		pulse(1, 1);
		rchk(ADDR_COUNT, 8'h00);
		test_done("external clear");
		serve <= 1'b1;
		wr(ADDR_CONST_A, 8'h01);
		wr(ADDR_CONST_B, 8'h03);
		rd(ADDR_STAT);
		wr(ADDR_STAT, 8'h0E);
		rchk(ADDR_STAT, 8'h1E);
		wr(ADDR_CTRL, 8'h91);
		rise(2);
		rise(2);
		chk(32'((t_rise - t_prev) / 10), 4 * div_tab[0]);
		chk(timer_out_pin, 1'b0);
		cycles(16);
		chk(timer_out_pin, 1'b1);
		test_done("clear on b");
		end_of_test();
	end
endmodule
